/* File: design/cps_defs.svh */
// shared constants of the codec power sequencer
`ifndef CPS_DEFS_SVH
`define CPS_DEFS_SVH
`define CPS_CLK_PERIOD_NS 10
`define CPS_NS_PER_MS 1000000
`define CPS_LATCH_MS 2
`define CPS_LATCH_MCLK 3000
`define CPS_N_CONV 9
`define CPS_ADDR_UPPER 4'h2
`define CPS_ADDR_SEL_W 3
`define CPS_REG_CTRL 4'h0
`define CPS_REG_STATUS 4'h4
`define CPS_REG_RATIO 4'h8
`define CPS_REG_LEVEL 4'hc
`define CPS_CTRL_RST 32'h0000_01ff
`define CPS_CTRL_MASK 32'h0003_01ff
`define CPS_RESP_OKAY 2'h0
`define CPS_RESP_SLVERR 2'h2
`define CPS_REF_CYCLES 16'h0040
`define CPS_CONV_CYCLES 16'h0040
`define CPS_RAMP_STEP 16'h0100
`define CPS_FS_TIMEOUT 16'hffff
`endif

/* File: design/cps_pkg.sv */
// types of the codec power sequencer
`include "cps_defs.svh"
package cps_pkg;
	typedef enum logic [2:0] {
		CPS_SEQ_RESET = 3'h0,
		CPS_SEQ_LOCK = 3'h1,
		CPS_SEQ_DOWN = 3'h2,
		CPS_SEQ_REF = 3'h3,
		CPS_SEQ_CONV = 3'h4,
		CPS_SEQ_RUN = 3'h5
	} cps_seq_type;
	typedef enum logic [1:0] {
		CPS_MODE_RESET = 2'h0,
		CPS_MODE_DOWN = 2'h1,
		CPS_MODE_RUN = 2'h2,
		CPS_MODE_MIXED = 2'h3
	} cps_mode_type;
	typedef struct packed {
		logic [13:0] rsv_hi;
		logic analog_supply_select;
		logic quiescent_ramp_enable;
		logic [6:0] rsv_lo;
		logic [`CPS_N_CONV-1:0] converter_power_down_bits;
	} cps_ctrl_type;
	typedef struct packed {
		logic [6:0] port_addr;
		logic q_at_top;
		logic ratio_ok;
		logic mute;
		logic port_ready;
		cps_mode_type mode;
		cps_seq_type seq;
	} cps_status_type;
endpackage

/* File: design/cps_ratio_meter.sv */
// frame sync period measurement in master clock cycles
`timescale 1ns/1ps
`default_nettype none
`include "cps_defs.svh"
module cps_ratio_meter #(
	parameter int CNT_W = 16,
	parameter logic [15:0] TIMEOUT = `CPS_FS_TIMEOUT
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// control
	input wire logic restart_in,
	input wire logic frame_sync_in,
	// result
	output logic [CNT_W-1:0] ratio_out,
	output logic valid_out,
	output logic update_out
);
	logic fs_d_r;
	logic armed_r;
	logic [CNT_W-1:0] cnt_r;
	logic rise;
	assign rise = frame_sync_in & ~fs_d_r;

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			fs_d_r <= 1'b0;
		end else begin
			fs_d_r <= frame_sync_in;
		end
	end

	// a period longer than the timeout means frame sync is gone
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in || restart_in) begin
			armed_r <= 1'b0;
			cnt_r <= '0;
			ratio_out <= '0;
			valid_out <= 1'b0;
			update_out <= 1'b0;
		end else begin
			update_out <= 1'b0;
			if (rise) begin
				cnt_r <= CNT_W'(1);
				armed_r <= 1'b1;
				if (armed_r) begin
					ratio_out <= cnt_r;
					valid_out <= 1'b1;
					update_out <= 1'b1;
				end
			end else if (armed_r) begin
				if (cnt_r == CNT_W'(TIMEOUT)) begin
					armed_r <= 1'b0;
					valid_out <= 1'b0;
				end else begin
					cnt_r <= cnt_r + 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: design/cps_q_ramp.sv */
// gradual charge and discharge of the quiescent node level
`timescale 1ns/1ps
`default_nettype none
`include "cps_defs.svh"
module cps_q_ramp #(
	parameter int LVL_W = 8,
	parameter logic [15:0] STEP_CYCLES = `CPS_RAMP_STEP
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// control
	input wire logic charge_in,
	input wire logic discharge_in,
	input wire logic hold_zero_in,
	// level
	output logic [LVL_W-1:0] level_out,
	output logic at_top_out
);
	logic [15:0] step_cnt_r;
	logic step;
	assign step = (step_cnt_r == STEP_CYCLES - 16'h0001);

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in || step) begin
			step_cnt_r <= '0;
		end else begin
			step_cnt_r <= step_cnt_r + 16'h0001;
		end
	end

	// discharge wins over charge so a power-down never pops
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in || hold_zero_in) begin
			level_out <= '0;
		end else if (step) begin
			if (discharge_in && level_out != '0) begin
				level_out <= level_out - 1'b1;
			end else if (charge_in && !discharge_in && level_out != '1) begin
				level_out <= level_out + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			at_top_out <= 1'b0;
		end else begin
			at_top_out <= (level_out == '1);
		end
	end
endmodule
`default_nettype wire

/* File: design/cps_top.sv */
// codec power sequencer: reset hold, address latch, power-up/down, register slave
// Summary of operation
// - reset pin low clears and clamps everything
// - address latched 2 ms plus 3000 clocks later
// - no register access before address latch
// - count clocks per frame sync period
// - references, converters and filter run, then unclamp
// - reset, power down, running, mixed state decode
// - ramp bit discharges quiescent node gradually
// - clocking change while powered up mutes
// - address select pins sampled at the address latch
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "cps_defs.svh"
module cps_top #(
	parameter int LATCH_CYCLES = `CPS_LATCH_MS * (`CPS_NS_PER_MS / `CPS_CLK_PERIOD_NS) + `CPS_LATCH_MCLK,
	parameter logic [15:0] REF_CYCLES = `CPS_REF_CYCLES,
	parameter logic [15:0] CONV_CYCLES = `CPS_CONV_CYCLES,
	parameter logic [15:0] RAMP_STEP = `CPS_RAMP_STEP,
	parameter logic [15:0] FS_TIMEOUT = `CPS_FS_TIMEOUT
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// device pins
	input wire logic rst_pin_n_in,
	input wire logic frame_sync_in,
	input wire logic [`CPS_ADDR_SEL_W-1:0] address_select_pins_in,
	// axi4-lite write
	input wire logic [3:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	// axi4-lite read
	input wire logic [3:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// analog and datapath controls
	output logic ref_enable_out,
	output logic [`CPS_N_CONV-1:0] conv_enable_out,
	output logic filter_run_out,
	output logic outputs_clamp_out,
	output logic mute_out,
	output logic q_discharge_out,
	output logic [7:0] q_level_out,
	output logic analog_supply_select_out,
	// control port
	output logic port_ready_out,
	output logic [6:0] port_addr_out
);
	localparam int LW = $clog2(LATCH_CYCLES + 1);

	// ====================================================
	// reset pin synchroniser and address latch delay
	logic pin_s1_r;
	logic pin_s2_r;
	logic [LW-1:0] lock_cnt_r;

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
		end else begin
			pin_s1_r <= rst_pin_n_in;
			pin_s2_r <= pin_s1_r;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in || !pin_s2_r) begin
			lock_cnt_r <= '0;
			port_ready_out <= 1'b0;
			port_addr_out <= '0;
		end else if (!port_ready_out) begin
			if (lock_cnt_r == LW'(LATCH_CYCLES - 1)) begin
				port_ready_out <= 1'b1;
				port_addr_out <= {`CPS_ADDR_UPPER, address_select_pins_in};
			end else begin
				lock_cnt_r <= lock_cnt_r + 1'b1;
			end
		end
	end

	// ====================================================
	// control register
	cps_pkg::cps_ctrl_type ctrl_r;
	logic [31:0] wr_merged;
	logic pd_all;
	logic pd_any_on;
	assign pd_all = &ctrl_r.converter_power_down_bits;
	assign pd_any_on = ~pd_all;

	logic aw_held_r;
	logic w_held_r;
	logic [3:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic wr_fire;
	logic wr_mapped;
	assign wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid_out;
	assign wr_mapped = (awaddr_r == `CPS_REG_CTRL) || (awaddr_r == `CPS_REG_STATUS) ||
		(awaddr_r == `CPS_REG_RATIO) || (awaddr_r == `CPS_REG_LEVEL);

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign wr_merged[gi*8 +: 8] = wstrb_r[gi] ? wdata_r[gi*8 +: 8] : ctrl_r[gi*8 +: 8];
		end
	endgenerate

	// registers clear while the reset pin is low and ignore writes until latched
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in || !pin_s2_r) begin
			ctrl_r <= `CPS_CTRL_RST;
		end else if (wr_fire && port_ready_out && awaddr_r == `CPS_REG_CTRL) begin
			ctrl_r <= wr_merged & `CPS_CTRL_MASK;
		end
	end

	// ====================================================
	// axi4-lite write channels
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out <= 1'b0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= `CPS_RESP_OKAY;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				awaddr_r <= s_axi_awaddr_in;
				aw_held_r <= 1'b1;
				s_axi_awready_out <= 1'b0;
			end else if (!aw_held_r && !s_axi_bvalid_out) begin
				s_axi_awready_out <= 1'b1;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				wdata_r <= s_axi_wdata_in;
				wstrb_r <= s_axi_wstrb_in;
				w_held_r <= 1'b1;
				s_axi_wready_out <= 1'b0;
			end else if (!w_held_r && !s_axi_bvalid_out) begin
				s_axi_wready_out <= 1'b1;
			end
			if (wr_fire) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= (port_ready_out && wr_mapped) ? `CPS_RESP_OKAY : `CPS_RESP_SLVERR;
			end else if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	// ====================================================
	// measurement, ramp and state decode
	logic [15:0] ratio;
	logic ratio_ok;
	logic ratio_upd;
	logic [15:0] ratio_lock_r;
	logic pd_all_d_r;
	logic meter_restart;
	logic q_top;
	logic [7:0] q_level;
	cps_pkg::cps_seq_type seq_r;
	cps_pkg::cps_mode_type mode;

	// a fresh measurement is forced each time every converter goes down
	assign meter_restart = ~pin_s2_r | (pd_all & ~pd_all_d_r);

	cps_ratio_meter #(
		.CNT_W(16),
		.TIMEOUT(FS_TIMEOUT)
	) u_meter (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.restart_in(meter_restart),
		.frame_sync_in(frame_sync_in),
		.ratio_out(ratio),
		.valid_out(ratio_ok),
		.update_out(ratio_upd)
	);

	cps_q_ramp #(
		.LVL_W(8),
		.STEP_CYCLES(RAMP_STEP)
	) u_ramp (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.charge_in(pin_s2_r),
		.discharge_in(ctrl_r.quiescent_ramp_enable),
		.hold_zero_in(~pin_s2_r),
		.level_out(q_level),
		.at_top_out(q_top)
	);

	always_comb begin
		if (!pin_s2_r) begin
			mode = cps_pkg::CPS_MODE_RESET;
		end else if (pd_all) begin
			mode = cps_pkg::CPS_MODE_DOWN;
		end else if (ctrl_r.converter_power_down_bits == '0) begin
			mode = cps_pkg::CPS_MODE_RUN;
		end else begin
			mode = cps_pkg::CPS_MODE_MIXED;
		end
	end

	// ====================================================
	// power sequence
	logic [15:0] seq_cnt_r;
	logic seq_leave;
	assign seq_leave = pd_all | ctrl_r.quiescent_ramp_enable;

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in || !pin_s2_r) begin
			seq_r <= cps_pkg::CPS_SEQ_RESET;
			seq_cnt_r <= '0;
		end else begin
			seq_cnt_r <= seq_cnt_r + 16'h0001;
			unique case (seq_r)
				cps_pkg::CPS_SEQ_RESET: begin
					seq_r <= cps_pkg::CPS_SEQ_LOCK;
				end
				cps_pkg::CPS_SEQ_LOCK: begin
					if (port_ready_out) begin
						seq_r <= cps_pkg::CPS_SEQ_DOWN;
					end
				end
				cps_pkg::CPS_SEQ_DOWN: begin
					seq_cnt_r <= '0;
					if (pd_any_on && ratio_ok && q_top && !ctrl_r.quiescent_ramp_enable) begin
						seq_r <= cps_pkg::CPS_SEQ_REF;
					end
				end
				cps_pkg::CPS_SEQ_REF: begin
					if (seq_leave) begin
						seq_r <= cps_pkg::CPS_SEQ_DOWN;
					end else if (seq_cnt_r == REF_CYCLES - 16'h0001) begin
						seq_r <= cps_pkg::CPS_SEQ_CONV;
						seq_cnt_r <= '0;
					end
				end
				cps_pkg::CPS_SEQ_CONV: begin
					if (seq_leave) begin
						seq_r <= cps_pkg::CPS_SEQ_DOWN;
					end else if (seq_cnt_r == CONV_CYCLES - 16'h0001) begin
						seq_r <= cps_pkg::CPS_SEQ_RUN;
					end
				end
				cps_pkg::CPS_SEQ_RUN: begin
					if (seq_leave) begin
						seq_r <= cps_pkg::CPS_SEQ_DOWN;
					end
				end
				default: begin
					seq_r <= cps_pkg::CPS_SEQ_RESET;
				end
			endcase
		end
	end

	// ====================================================
	// clocking change detection
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in || !pin_s2_r) begin
			pd_all_d_r <= 1'b1;
			ratio_lock_r <= '0;
			mute_out <= 1'b0;
		end else begin
			pd_all_d_r <= pd_all;
			if (ratio_upd && (pd_all || ratio_lock_r == '0)) begin
				ratio_lock_r <= ratio;
			end
			// cleared by a full power-down, where detection is off, or by the reset pin
			if (pd_any_on && ((ratio_upd && ratio != ratio_lock_r && ratio_lock_r != '0) ||
				(!ratio_ok && seq_r != cps_pkg::CPS_SEQ_DOWN))) begin
				mute_out <= 1'b1;
			end else if (pd_all) begin
				mute_out <= 1'b0;
			end
		end
	end

	// ====================================================
	// registered analog controls
	logic seq_pwr;
	logic seq_conv;
	assign seq_pwr = (seq_r == cps_pkg::CPS_SEQ_REF) | seq_conv;
	assign seq_conv = (seq_r == cps_pkg::CPS_SEQ_CONV) | (seq_r == cps_pkg::CPS_SEQ_RUN);

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in || !pin_s2_r) begin
			ref_enable_out <= 1'b0;
			conv_enable_out <= '0;
			filter_run_out <= 1'b0;
			outputs_clamp_out <= 1'b1;
			q_discharge_out <= 1'b0;
			q_level_out <= '0;
			analog_supply_select_out <= 1'b0;
		end else begin
			ref_enable_out <= seq_pwr;
			conv_enable_out <= {`CPS_N_CONV{seq_conv}} & ~ctrl_r.converter_power_down_bits;
			filter_run_out <= seq_conv;
			outputs_clamp_out <= (seq_r != cps_pkg::CPS_SEQ_RUN) || seq_leave;
			q_discharge_out <= ctrl_r.quiescent_ramp_enable;
			q_level_out <= q_level;
			analog_supply_select_out <= ctrl_r.analog_supply_select;
		end
	end

	// ====================================================
	// axi4-lite read channel
	cps_pkg::cps_status_type status;
	logic [31:0] rd_word;
	logic [1:0] rd_resp;
	assign status = '{port_addr: port_addr_out, q_at_top: q_top, ratio_ok: ratio_ok,
		mute: mute_out, port_ready: port_ready_out, mode: mode, seq: seq_r};

	always_comb begin
		rd_word = '0;
		rd_resp = `CPS_RESP_OKAY;
		unique case (s_axi_araddr_in)
			`CPS_REG_CTRL: rd_word = ctrl_r;
			`CPS_REG_STATUS: rd_word = {16'h0000, status};
			`CPS_REG_RATIO: rd_word = {16'h0000, ratio};
			`CPS_REG_LEVEL: rd_word = {24'h000000, q_level};
			default: rd_resp = `CPS_RESP_SLVERR;
		endcase
		if (!port_ready_out) begin
			rd_word = '0;
			rd_resp = `CPS_RESP_SLVERR;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= '0;
			s_axi_rresp_out <= `CPS_RESP_OKAY;
		end else if (s_axi_arvalid_in && s_axi_arready_out) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out <= rd_word;
			s_axi_rresp_out <= rd_resp;
		end else if (s_axi_rvalid_out && s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_arready_out <= 1'b1;
		end else if (!s_axi_rvalid_out) begin
			s_axi_arready_out <= 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: test/cps_top_monitor.sv */
// assertion checker bound to the codec power sequencer top
`timescale 1ns/1ps
`default_nettype none
`include "cps_defs.svh"
module cps_top_monitor #(
	parameter int LATCH_CYCLES = 50
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// watched ports
	input wire logic rst_pin_n_in,
	input wire logic [1:0] s_axi_bresp_out,
	input wire logic s_axi_bvalid_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic [1:0] s_axi_rresp_out,
	input wire logic s_axi_rvalid_out,
	input wire logic ref_enable_out,
	input wire logic [`CPS_N_CONV-1:0] conv_enable_out,
	input wire logic filter_run_out,
	input wire logic outputs_clamp_out,
	input wire logic [7:0] q_level_out,
	input wire logic port_ready_out,
	input wire logic [6:0] port_addr_out
);
	// ====================
	// cycles since the reset pin was last seen low, saturating
	logic [31:0] since_r;
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in || !rst_pin_n_in) begin
			since_r <= 32'h0;
		end else if (since_r < 32'(LATCH_CYCLES + 8)) begin
			since_r <= since_r + 32'h1;
		end
	end
	// ====================
	// properties
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	a_reset_clamp: assert property (!rst_pin_n_in [*6] |-> outputs_clamp_out && !ref_enable_out && conv_enable_out == '0)
		else $error("outputs not clamped in reset");
	a_reset_lock: assert property (!rst_pin_n_in [*4] |-> !port_ready_out && port_addr_out == 7'h00)
		else $error("port open during reset");
	a_latch_delay: assert property ($rose(port_ready_out) |-> since_r == 32'(LATCH_CYCLES + 2))
		else $error("address latched at wrong time");
	a_addr_upper: assert property (port_ready_out |-> port_addr_out[6:3] == `CPS_ADDR_UPPER)
		else $error("latched address upper bits wrong");
	a_locked_write: assert property ($rose(s_axi_bvalid_out) && !port_ready_out |-> s_axi_bresp_out == `CPS_RESP_SLVERR)
		else $error("write answered before latch");
	a_locked_read: assert property ($rose(s_axi_rvalid_out) && !port_ready_out |->
		s_axi_rresp_out == `CPS_RESP_SLVERR && s_axi_rdata_out == 32'h0)
		else $error("read answered before latch");
	a_run_unclamp: assert property (!outputs_clamp_out |-> ref_enable_out && filter_run_out && conv_enable_out != '0)
		else $error("unclamped without converters running");
	a_unclamp_order: assert property ($fell(outputs_clamp_out) |-> $past(filter_run_out, 8) && $past(ref_enable_out, 8))
		else $error("unclamped too early");
	a_ref_first: assert property ($rose(filter_run_out) |-> $past(ref_enable_out, 8))
		else $error("converters started before references");
	a_ramp_gradual: assert property (rst_pin_n_in && $past(rst_pin_n_in, 4) && q_level_out != $past(q_level_out) |->
		q_level_out - $past(q_level_out) == 8'h01 || $past(q_level_out) - q_level_out == 8'h01)
		else $error("quiescent level jumped");
endmodule
bind cps_top cps_top_monitor #(.LATCH_CYCLES(LATCH_CYCLES)) u_mon (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
	.rst_pin_n_in(rst_pin_n_in), .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
	.s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
	.ref_enable_out(ref_enable_out), .conv_enable_out(conv_enable_out), .filter_run_out(filter_run_out),
	.outputs_clamp_out(outputs_clamp_out), .q_level_out(q_level_out), .port_ready_out(port_ready_out),
	.port_addr_out(port_addr_out));
`default_nettype wire

/* File: test/cps_host_model.sv */
// host controller model driving the register port as an axi4-lite master
`timescale 1ns/1ps
`default_nettype none
module cps_host_model (
	// clock
	input wire logic clk_in,
	// write channels
	output var logic [3:0] awaddr_out,
	output var logic awvalid_out,
	input wire logic awready_in,
	output var logic [31:0] wdata_out,
	output var logic [3:0] wstrb_out,
	output var logic wvalid_out,
	input wire logic wready_in,
	input wire logic [1:0] bresp_in,
	input wire logic bvalid_in,
	output var logic bready_out,
	// read channels
	output var logic [3:0] araddr_out,
	output var logic arvalid_out,
	input wire logic arready_in,
	input wire logic [31:0] rdata_in,
	input wire logic [1:0] rresp_in,
	input wire logic rvalid_in,
	output var logic rready_out
);
	int timeouts = 0;
	initial begin
		{awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out, bready_out} = '0;
		{araddr_out, arvalid_out, rready_out} = '0;
	end
	// ====================
	// each channel is released only at the edge that takes it
	task automatic write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		r = 2'h3;
		@(posedge clk_in);
		awaddr_out <= a;
		awvalid_out <= 1'b1;
		wdata_out <= d;
		wstrb_out <= 4'hf;
		wvalid_out <= 1'b1;
		bready_out <= 1'b1;
		while (n < 500) begin
			@(posedge clk_in);
			n++;
			if (awvalid_out && awready_in) awvalid_out <= 1'b0;
			if (wvalid_out && wready_in) wvalid_out <= 1'b0;
			if (bvalid_in && bready_out) begin
				r = bresp_in;
				bready_out <= 1'b0;
				break;
			end
		end
		if (n >= 500) timeouts++;
	endtask
	task automatic read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		r = 2'h3;
		d = 32'h0;
		@(posedge clk_in);
		araddr_out <= a;
		arvalid_out <= 1'b1;
		rready_out <= 1'b1;
		while (n < 500) begin
			@(posedge clk_in);
			n++;
			if (arvalid_out && arready_in) arvalid_out <= 1'b0;
			if (rvalid_in && rready_out) begin
				r = rresp_in;
				d = rdata_in;
				rready_out <= 1'b0;
				break;
			end
		end
		if (n >= 500) timeouts++;
	endtask
endmodule
`default_nettype wire

/* File: test/test_codec_power_sequencer.sv */
// self-checking bench for the codec power sequencer
`timescale 1ns/1ps
`default_nettype none
`include "cps_defs.svh"
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module test_codec_power_sequencer;
	localparam int LATCH = 50;
	localparam logic [2:0] PINS = 3'h5;
	logic ref_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic rst_pin_n = 1'b0;
	logic fs = 1'b0;
	logic fs_en = 1'b0;
	int fs_per = 40;
	int fc = 0;
	int n_errors = 0;
	int checks_done = 0;
	wire logic [3:0] awaddr, araddr, wstrb;
	wire logic [31:0] wdata, rdata;
	wire logic [1:0] bresp, rresp;
	wire logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	wire logic ref_en, filt, clamp, mute, q_dis, supply, ready;
	wire logic [8:0] conv;
	wire logic [7:0] level;
	wire logic [6:0] addr;
	always #5 ref_clk_in = ~ref_clk_in;
	// ====================
	// frame sync of fs_per clocks, held low when stopped
	always @(posedge ref_clk_in) begin
		if (!fs_en) begin
			fs <= 1'b0;
			fc <= 0;
		end else if (fc >= fs_per - 1) begin
			fs <= 1'b1;
			fc <= 0;
		end else begin
			if (fc == fs_per / 2) fs <= 1'b0;
			fc <= fc + 1;
		end
	end
	cps_top #(.LATCH_CYCLES(LATCH), .RAMP_STEP(16'h0002), .FS_TIMEOUT(16'h0258)) dut (.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in), .rst_pin_n_in(rst_pin_n), .frame_sync_in(fs), .address_select_pins_in(PINS),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .ref_enable_out(ref_en), .conv_enable_out(conv), .filter_run_out(filt),
		.outputs_clamp_out(clamp), .mute_out(mute), .q_discharge_out(q_dis), .q_level_out(level),
		.analog_supply_select_out(supply), .port_ready_out(ready), .port_addr_out(addr));
	cps_host_model host (.clk_in(ref_clk_in), .awaddr_out(awaddr), .awvalid_out(awvalid), .awready_in(awready),
		.wdata_out(wdata), .wstrb_out(wstrb), .wvalid_out(wvalid), .wready_in(wready), .bresp_in(bresp),
		.bvalid_in(bvalid), .bready_out(bready), .araddr_out(araddr), .arvalid_out(arvalid), .arready_in(arready),
		.rdata_in(rdata), .rresp_in(rresp), .rvalid_in(rvalid), .rready_out(rready));
	// ====================
	// shared tasks
	task automatic close_out;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic stop(input string nm);
		n_errors++;
		$display("ERROR %s timed out", nm);
		close_out();
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		host.write(a, d, r);
		if (host.timeouts != 0) stop("write");
		`CHK("bresp", er, r);
	endtask
	task automatic rd(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
		logic [1:0] r;
		host.read(a, d, r);
		if (host.timeouts != 0) stop("read");
		`CHK("rresp", er, r);
	endtask
	function automatic logic cond(input int s);
		case (s)
			0: return ready;
			1: return !clamp;
			2: return mute;
			3: return level == 8'h00;
			default: return clamp && !mute;
		endcase
	endfunction
	task automatic wait_until(input int s, input int lim, output int n);
		n = 0;
		while (cond(s) !== 1'b1 && n < lim) begin
			@(posedge ref_clk_in);
			#1;
			n++;
		end
		if (n >= lim) stop("wait");
	endtask
	// ====================
	// scenarios
	task automatic s_reset_hold;
		int n;
		logic [31:0] d;
		#1;
		`CHK("clamp", 1'b1, clamp);
		`CHK("conv", 9'h000, conv);
		`CHK("addr", 7'h00, addr);
		rd(`CPS_REG_CTRL, `CPS_RESP_SLVERR, d);
		`CHK("locked data", 32'h0, d);
		wr(`CPS_REG_CTRL, 32'h0, `CPS_RESP_SLVERR);
		@(posedge ref_clk_in);
		rst_pin_n <= 1'b1;
		wait_until(0, LATCH + 20, n);
		`CHK("latch delay", LATCH + 2, n);
	endtask
	task automatic s_latch;
		logic [31:0] d;
		`CHK("port addr", {`CPS_ADDR_UPPER, PINS}, addr);
		rd(`CPS_REG_CTRL, `CPS_RESP_OKAY, d);
		`CHK("ctrl reset", `CPS_CTRL_RST, d);
		rd(4'h2, `CPS_RESP_SLVERR, d);
		wr(`CPS_REG_STATUS, 32'hffff_ffff, `CPS_RESP_OKAY);
		rd(`CPS_REG_STATUS, `CPS_RESP_OKAY, d);
		`CHK("mode down", cps_pkg::CPS_MODE_DOWN, d[4:3]);
	endtask
	task automatic s_power_up;
		int n;
		logic [31:0] d;
		fs_en = 1'b1;
		wr(`CPS_REG_CTRL, 32'h0002_0000, `CPS_RESP_OKAY);
		wait_until(1, 3000, n);
		`CHK("conv", 9'h1ff, conv);
		`CHK("ref", 1'b1, ref_en);
		`CHK("filter", 1'b1, filt);
		`CHK("supply", 1'b1, supply);
		rd(`CPS_REG_RATIO, `CPS_RESP_OKAY, d);
		`CHK("ratio", fs_per, d[15:0]);
		rd(`CPS_REG_STATUS, `CPS_RESP_OKAY, d);
		`CHK("mode run", cps_pkg::CPS_MODE_RUN, d[4:3]);
		`CHK("no mute", 1'b0, mute);
	endtask
	task automatic s_power_down;
		int n;
		logic [31:0] d;
		wr(`CPS_REG_CTRL, 32'h0002_01ff, `CPS_RESP_OKAY);
		wait_until(4, 800, n);
		rd(`CPS_REG_STATUS, `CPS_RESP_OKAY, d);
		`CHK("mode down", cps_pkg::CPS_MODE_DOWN, d[4:3]);
	endtask
	task automatic s_discharge;
		int n;
		logic [31:0] d;
		wr(`CPS_REG_CTRL, 32'h0003_01ff, `CPS_RESP_OKAY);
		wait_until(3, 3000, n);
		`CHK("discharge", 1'b1, q_dis);
		`CHK("gradual", 1'b1, n > 200);
		fs_en = 1'b0;
		@(posedge ref_clk_in);
		rst_pin_n <= 1'b0;
		repeat (8) @(posedge ref_clk_in);
		#1;
		`CHK("clamp", 1'b1, clamp);
		`CHK("ready", 1'b0, ready);
		rd(`CPS_REG_CTRL, `CPS_RESP_SLVERR, d);
	endtask
	initial begin
		int n;
		repeat (20) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		repeat (6) @(posedge ref_clk_in);
		s_reset_hold();
		s_latch();
		s_power_up();
		fs_per = 50;
		wait_until(2, 800, n);
		s_power_down();
		#1;
		fs_per = 40;
		// let the meter settle on the new period before powering up again
		repeat (200) @(posedge ref_clk_in);
		s_power_up();
		s_power_down();
		s_discharge();
		close_out();
	end
endmodule
`default_nettype wire
